//--- hdl/bpsc_pkg.sv
// constants and types of the bridge power state control block
// Operation
// - wake event flag always reads zero
// - report scale and select fields read zero
// - wake enable stored, read back, no effect
// - power state field 00=D0, 11=D3
// - writes of 01 or 10 discarded silently
// - in D3 only configuration accesses accepted
// - in D3 no interrupts, no memory-mapped claims
// - not D0: abort downstream except type 0
// - aborted cycles flag host master abort bit
// - D3cold needs nothing beyond D3 behaviour
package bpsc_pkg;
    localparam logic [7:0] PMCS_OFFSET = 8'h84;
    localparam logic [31:0] PMCS_RESET = 32'h00000008;
    // bit 3 reads one, as the register default shows
    localparam logic [31:0] PMCS_FIXED_ONES = 32'h00000008;
    localparam int PS_LSB = 0;
    localparam int PS_MSB = 1;
    localparam int WAKE_EN_BIT = 8;
    localparam int SELECT_LSB = 9;
    localparam int SELECT_MSB = 12;
    localparam int SCALE_LSB = 13;
    localparam int SCALE_MSB = 14;
    localparam int WAKE_FLAG_BIT = 15;
    localparam int HOST_MA_BIT = 13;
    localparam logic [1:0] PS_CODE_D0 = 2'h0;
    localparam logic [1:0] PS_CODE_D1 = 2'h1;
    localparam logic [1:0] PS_CODE_D2 = 2'h2;
    localparam logic [1:0] PS_CODE_D3 = 2'h3;
    localparam logic WAKE_EN_RESET = 1'b0;

    typedef enum logic [1:0] {
        BPSC_D0 = 2'b01,
        BPSC_D3 = 2'b10
    } bpsc_pstate_t;
endpackage

//--- hdl/bpsc_pm_if.sv
// power state carrier between register and cycle gate
`timescale 1ns/1ps
interface bpsc_pm_if;
    logic in_d0;
    logic wake_en;
    logic [1:0] ps_code;
    modport src (output in_d0, output wake_en, output ps_code);
    modport snk (input in_d0, input wake_en, input ps_code);
endinterface

//--- hdl/bpsc_pm_regs.sv
// power state and wake enable storage
`timescale 1ns/1ps
module bpsc_pm_regs
    import bpsc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic wr_i,
    input wire logic [1:0] be_i,
    input wire logic [15:0] wdata_i,
    bpsc_pm_if.src pm
);
    bpsc_pstate_t state_r;
    bpsc_pstate_t state_nxt;
    logic wake_en_r;
    logic wake_en_nxt;
    logic [1:0] req_code;

    assign req_code = wdata_i[PS_MSB:PS_LSB];

    always_comb begin
        state_nxt = state_r;
        wake_en_nxt = wake_en_r;
        if (wr_i && be_i[0]) begin
            case (req_code)
                PS_CODE_D0: state_nxt = BPSC_D0;
                PS_CODE_D3: state_nxt = BPSC_D3;
                PS_CODE_D1, PS_CODE_D2: state_nxt = state_r;
                default: state_nxt = state_r;
            endcase
        end
        if (wr_i && be_i[1]) begin
            wake_en_nxt = wdata_i[WAKE_EN_BIT];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state_r <= BPSC_D0;
            wake_en_r <= WAKE_EN_RESET;
        end else begin
            state_r <= state_nxt;
            wake_en_r <= wake_en_nxt;
        end
    end

    assign pm.in_d0 = (state_r == BPSC_D0);
    assign pm.wake_en = wake_en_r;
    assign pm.ps_code = (state_r == BPSC_D0) ? PS_CODE_D0 : PS_CODE_D3;
endmodule

//--- hdl/bpsc_cycle_gate.sv
// downstream cycle claim or master abort decision
`timescale 1ns/1ps
module bpsc_cycle_gate
    import bpsc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic dn_valid_i,
    input wire logic dn_type0_cfg_i,
    bpsc_pm_if.snk pm,
    output logic claim_o,
    output logic abort_o
);
    logic claim_r;
    logic claim_nxt;
    logic abort_r;
    logic abort_nxt;

    always_comb begin
        claim_nxt = 1'b0;
        abort_nxt = 1'b0;
        if (dn_valid_i) begin
            // abort unless D0 or type 0
            if (pm.in_d0 || dn_type0_cfg_i) begin
                claim_nxt = 1'b1;
            end else begin
                abort_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            claim_r <= 1'b0;
            abort_r <= 1'b0;
        end else begin
            claim_r <= claim_nxt;
            abort_r <= abort_nxt;
        end
    end

    assign claim_o = claim_r;
    assign abort_o = abort_r;
endmodule

//--- hdl/bpsc_power_ctrl.sv
// bridge power state control: config register, cycle and interrupt gating
`timescale 1ns/1ps
module bpsc_power_ctrl
    import bpsc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic cfg_req_i,
    input wire logic cfg_we_i,
    input wire logic [7:0] cfg_addr_i,
    input wire logic [3:0] cfg_be_i,
    input wire logic [31:0] cfg_wdata_i,
    output logic cfg_ack_o,
    output logic cfg_hit_o,
    output logic [31:0] cfg_rdata_o,
    input wire logic dn_valid_i,
    input wire logic dn_type0_cfg_i,
    output logic dn_claim_o,
    output logic dn_master_abort_o,
    output logic host_sts_ma_set_o,
    input wire logic mmr_req_i,
    output logic mmr_claim_o,
    input wire logic irq_req_i,
    output logic irq_o,
    output logic wake_request_signal_o,
    output logic [1:0] power_state_o
);
    bpsc_pm_if pm_bus ();

    logic reg_sel;
    logic reg_wr;
    logic [31:0] reg_view;
    logic ack_r;
    logic ack_nxt;
    logic hit_r;
    logic hit_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic mmr_claim_r;
    logic mmr_claim_nxt;
    logic irq_r;
    logic irq_nxt;
    logic [1:0] ps_r;
    logic [1:0] ps_nxt;
    logic gate_abort;

    // dword decode, byte lanes taken from cfg_be_i
    always_comb begin
        if (cfg_addr_i[7:2] == PMCS_OFFSET[7:2]) begin
            reg_sel = 1'b1;
        end else begin
            reg_sel = 1'b0;
        end
    end

    // config access works in every state
    assign reg_wr = cfg_req_i && cfg_we_i && reg_sel;

    bpsc_pm_regs u_regs (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .wr_i(reg_wr),
        .be_i(cfg_be_i[1:0]),
        .wdata_i(cfg_wdata_i[15:0]),
        .pm(pm_bus.src)
    );

    bpsc_cycle_gate u_gate (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .dn_valid_i(dn_valid_i),
        .dn_type0_cfg_i(dn_type0_cfg_i),
        .pm(pm_bus.snk),
        .claim_o(dn_claim_o),
        .abort_o(gate_abort)
    );

    // register image; reserved bits zero
    always_comb begin
        reg_view = PMCS_FIXED_ONES;
        reg_view[PS_MSB:PS_LSB] = pm_bus.ps_code;
        reg_view[WAKE_EN_BIT] = pm_bus.wake_en;
        reg_view[SELECT_MSB:SELECT_LSB] = 4'h0;
        reg_view[SCALE_MSB:SCALE_LSB] = 2'h0;
        reg_view[WAKE_FLAG_BIT] = 1'b0;
    end

    // write always completes, ack regardless of data
    always_comb begin
        ack_nxt = cfg_req_i;
        hit_nxt = cfg_req_i && reg_sel;
        rdata_nxt = 32'h00000000;
        if (cfg_req_i && !cfg_we_i && reg_sel) begin
            rdata_nxt = reg_view;
        end
    end

    // memory-mapped claims and interrupts only in D0
    always_comb begin
        mmr_claim_nxt = mmr_req_i && pm_bus.in_d0;
        irq_nxt = irq_req_i && pm_bus.in_d0;
        ps_nxt = pm_bus.ps_code;
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ack_r <= 1'b0;
            hit_r <= 1'b0;
            rdata_r <= 32'h00000000;
            mmr_claim_r <= 1'b0;
            irq_r <= 1'b0;
            ps_r <= PMCS_RESET[PS_MSB:PS_LSB];
        end else begin
            ack_r <= ack_nxt;
            hit_r <= hit_nxt;
            rdata_r <= rdata_nxt;
            mmr_claim_r <= mmr_claim_nxt;
            irq_r <= irq_nxt;
            ps_r <= ps_nxt;
        end
    end

    assign cfg_ack_o = ack_r;
    assign cfg_hit_o = hit_r;
    assign cfg_rdata_o = rdata_r;
    assign mmr_claim_o = mmr_claim_r;
    assign irq_o = irq_r;
    assign power_state_o = ps_r;
    assign dn_master_abort_o = gate_abort;
    // abort logged in host status bit 13
    assign host_sts_ma_set_o = gate_abort;
    // D3cold same as D3; enable drives nothing, no wake source
    assign wake_request_signal_o = 1'b0;
endmodule

//--- dv/bpsc_power_ctrl_sva.sv
// assertions on the power state control ports
`timescale 1ns/1ps
module bpsc_power_ctrl_sva
    import bpsc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic cfg_req_i,
    input wire logic [7:0] cfg_addr_i,
    input wire logic dn_valid_i,
    input wire logic dn_type0_cfg_i,
    input wire logic mmr_req_i,
    input wire logic irq_req_i,
    input wire logic irq_o,
    input wire logic cfg_ack_o,
    input wire logic cfg_hit_o,
    input wire logic [31:0] cfg_rdata_o,
    input wire logic dn_claim_o,
    input wire logic dn_master_abort_o,
    input wire logic host_sts_ma_set_o,
    input wire logic mmr_claim_o,
    input wire logic wake_request_signal_o,
    input wire logic [1:0] power_state_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // power_state_o lags the register, so it shows the state a request met
    wire d0 = power_state_o == PS_CODE_D0;
    wire at_reg = cfg_addr_i[7:2] == PMCS_OFFSET[7:2];
    a_ack_hit_next: assert property (cfg_req_i |=> cfg_ack_o && cfg_hit_o == $past(at_reg))
        else $error("config answer wrong");
    a_fields_zero: assert property (cfg_ack_o |-> cfg_rdata_o[15:9] == 7'h00)
        else $error("fixed fields not zero");
    a_reserved_zero: assert property (cfg_ack_o |-> cfg_rdata_o[31:16] == 16'h0000)
        else $error("reserved bits set");
    a_state_legal: assert property (d0 || power_state_o == PS_CODE_D3)
        else $error("unsupported state held");
    a_dn_decide: assert property (dn_valid_i |=> dn_claim_o != dn_master_abort_o
        && dn_master_abort_o == (!d0 && !$past(dn_type0_cfg_i)))
        else $error("downstream decision wrong");
    a_irq_gated: assert property (irq_o |-> d0 && $past(irq_req_i))
        else $error("interrupt outside D0");
    a_miss_rdata: assert property (cfg_ack_o && !cfg_hit_o |-> cfg_rdata_o == 32'h00000000)
        else $error("miss returned data");
    a_ma_logged: assert property (host_sts_ma_set_o == dn_master_abort_o)
        else $error("abort not logged");
    a_mmr_gated: assert property (mmr_req_i |=> mmr_claim_o == d0)
        else $error("mmr claim wrong");
    a_wake_never: assert property (!wake_request_signal_o)
        else $error("wake request raised");
endmodule
bind bpsc_power_ctrl bpsc_power_ctrl_sva chk (.clk_i, .rst_n_i, .cfg_req_i, .cfg_addr_i,
    .dn_valid_i, .dn_type0_cfg_i, .mmr_req_i, .irq_req_i, .irq_o, .cfg_ack_o, .cfg_hit_o,
    .cfg_rdata_o,
    .dn_claim_o, .dn_master_abort_o, .host_sts_ma_set_o, .mmr_claim_o,
    .wake_request_signal_o, .power_state_o);

//--- dv/bpsc_host_model.sv
// host software model making config accesses
`timescale 1ns/1ps
module bpsc_host_model (
    input wire logic clk_i,
    input wire logic ack_i,
    input wire logic hit_i,
    input wire logic [31:0] rdata_i,
    output logic req_o = 1'b0,
    output logic we_o = 1'b0,
    output logic [7:0] addr_o = 8'h00,
    output logic [3:0] be_o = 4'h0,
    output logic [31:0] wdata_o = 32'h0
);
    // one-cycle request pulse; a held request would be a second access
    task automatic access(input logic w, input logic [7:0] a, input logic [3:0] b,
        input logic [31:0] d, output logic h, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        #1;
        {req_o, we_o, addr_o, be_o, wdata_o} = {1'b1, w, a, b, d};
        @(posedge clk_i);
        #1;
        // released lines show no stale value
        {req_o, addr_o, wdata_o} = {1'b0, ~a, ~d};
        while (ack_i !== 1'b1 && n < 4) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        h = hit_i;
        q = rdata_i;
    endtask
endmodule

//--- dv/test_bridge_power_state_control.sv
// bench for the bridge power state control block
`timescale 1ns/1ps
module test_bridge_power_state_control;
    import bpsc_pkg::*;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic cfg_req_i, cfg_we_i, cfg_ack_o, cfg_hit_o, h;
    logic dn_claim_o, dn_master_abort_o, host_sts_ma_set_o, mmr_claim_o, irq_o;
    logic wake_request_signal_o;
    logic dn_valid_i = 1'b0, dn_type0_cfg_i = 1'b0, mmr_req_i = 1'b0, irq_req_i = 1'b0;
    logic [7:0] cfg_addr_i;
    logic [3:0] cfg_be_i, b;
    logic [31:0] cfg_wdata_i, cfg_rdata_o, q, d;
    logic [1:0] power_state_o;
    int seed = 38, fail_count = 0, checks = 0, ps = 0, wen = 0;
    initial forever #12.5 clk_i = ~clk_i;
    bpsc_power_ctrl uut (.clk_i, .rst_n_i, .cfg_req_i, .cfg_we_i, .cfg_addr_i, .cfg_be_i,
        .cfg_wdata_i, .cfg_ack_o, .cfg_hit_o, .cfg_rdata_o, .dn_valid_i, .dn_type0_cfg_i,
        .dn_claim_o, .dn_master_abort_o, .host_sts_ma_set_o, .mmr_req_i, .mmr_claim_o,
        .irq_req_i, .irq_o, .wake_request_signal_o, .power_state_o);
    bpsc_host_model host (.clk_i, .ack_i(cfg_ack_o), .hit_i(cfg_hit_o), .rdata_i(cfg_rdata_o),
        .req_o(cfg_req_i), .we_o(cfg_we_i), .addr_o(cfg_addr_i), .be_o(cfg_be_i),
        .wdata_o(cfg_wdata_i));
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        host.access(1'b0, a, 4'hF, 32'h0, h, q);
        chk(q, e);
        chk(32'(h), 32'(a == PMCS_OFFSET));
    endtask
    task automatic stop_test;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clk_i);
        #1;
        rst_n_i = 1'b1;
        rd_chk(PMCS_OFFSET, PMCS_RESET);
        for (int i = 0; i < 24; i++) begin
            {d, b} = {$random(seed), 4'($random(seed))};
            d[1:0] = 2'(i);
            // make sure D3 is entered a few times
            b[0] = b[0] | (i % 8 == 3);
            host.access(1'b1, PMCS_OFFSET, b, d, h, q);
            if (b[0] && (i % 4 == 0 || i % 4 == 3)) ps = i % 4;
            if (b[1]) wen = d[8];
            rd_chk(PMCS_OFFSET, 32'(wen * 256 + 8 + ps));
            chk(32'(power_state_o), 32'(ps));
            {dn_type0_cfg_i, mmr_req_i, irq_req_i, dn_valid_i} = {3'($random(seed)), 1'b1};
            @(posedge clk_i);
            #1;
            dn_valid_i = 1'b0;
            chk(32'({dn_claim_o, dn_master_abort_o, host_sts_ma_set_o, mmr_claim_o, irq_o,
                wake_request_signal_o}), 32'({ps == 0 || dn_type0_cfg_i,
                {2{ps != 0 && !dn_type0_cfg_i}}, mmr_req_i && ps == 0,
                irq_req_i && ps == 0, 1'b0}));
        end
        host.access(1'b1, PMCS_OFFSET, 4'h3, 32'h0, h, q);
        host.access(1'b1, 8'h88, 4'hF, 32'h103, h, q);
        chk({31'h0, h}, 32'h0);
        rd_chk(PMCS_OFFSET, PMCS_RESET);
        rd_chk(8'h88, 32'h0);
        host.access(1'b1, PMCS_OFFSET, 4'h3, 32'h103, h, q);
        rst_n_i = 1'b0;
        repeat (2) @(posedge clk_i);
        #1;
        rst_n_i = 1'b1;
        rd_chk(PMCS_OFFSET, PMCS_RESET);
        chk(32'(power_state_o), 32'h0);
        stop_test();
    end
    initial begin
        #20000;
        fail_count++;
        stop_test();
    end
endmodule
